// *** src/stcm_defines.vh ***
// Constants for the service timer and clock monitor block
`ifndef STCM_DEFINES_VH
`define STCM_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define STCM_OFS_SERVICE   8'h00
`define STCM_OFS_STATUS    8'h04
`define STCM_OFS_MASK      8'h08
`define STCM_OFS_CONTROL   8'h0C
`define STCM_OFS_IDLE_CNT  8'h10

// ****************************************
// Service register fields
// ****************************************
`define STCM_SEL_HI        7
`define STCM_SEL_LO        6
`define STCM_KEY_HI        5
`define STCM_KEY_LO        1
`define STCM_CM_BIT        0
`define STCM_KEY_VALUE     5'h0C
`define STCM_SEL_RESET     2'h3
`define STCM_CM_RESET      1'b1

// ****************************************
// Status and mask bits
// ****************************************
`define STCM_ST_SVC_ERR    0
`define STCM_ST_CLK_ERR    1
`define STCM_ST_IDLE_PND   2
`define STCM_ST_WIDTH      3

// ****************************************
// Timing counts in instruction cycles
// ****************************************
`define STCM_LOWER_CYC     17'h00100
`define STCM_UPPER_BASE    17'h02000
`define STCM_STRETCH_CYC   5'h10
`define STCM_IDLE_TAP      12

`endif

// *** src/stcm_window_timer.v ***
// Service window counter with lower and upper limit flags
`include "stcm_defines.vh"
`default_nettype none

module stcm_window_timer #(
  parameter CNT_W = 17
) (
  // Clock and reset
  input  wire             i_core_clk,
  input  wire             i_srst,
  // Control
  input  wire             i_restart,
  input  wire             i_run,
  input  wire [1:0]       i_sel,
  // Status
  output wire             o_early,
  output reg              o_expired
);

  // ****************************************
  // Upper limit decode
  // ****************************************
  function [CNT_W-1:0] stcm_upper;
    input [1:0] sel;
    begin
      stcm_upper = `STCM_UPPER_BASE << sel; // RL16
    end
  endfunction

  reg [CNT_W-1:0] count_ff;
  reg [CNT_W-1:0] nxt_count;

  // Frozen while not running, so a halted core keeps its place
  always @* begin
    nxt_count = count_ff;
    if (i_restart) begin
      nxt_count = {CNT_W{1'b0}};
    end else if (i_run && !o_expired) begin
      nxt_count = count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Counter and expiry flag
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      count_ff  <= {CNT_W{1'b0}};
      o_expired <= 1'b0;
    end else begin
      count_ff  <= nxt_count;
      o_expired <= !i_restart && (nxt_count >= stcm_upper(i_sel) - {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

  assign o_early = (count_ff < `STCM_LOWER_CYC);

endmodule // stcm_window_timer

`default_nettype wire

// *** src/stcm_fault_stretch.v ***
// Open-drain fault pin driver with low-level stretch
`include "stcm_defines.vh"
`default_nettype none

module stcm_fault_stretch #(
  parameter STR_W = 5
) (
  // Clock and reset
  input  wire             i_core_clk,
  input  wire             i_srst,
  // Fault causes
  input  wire             i_trig,
  input  wire             i_hold,
  // Pin sense
  input  wire             i_pin_in,
  // Pin drive
  output reg              o_drive,
  output reg              o_release
);

  localparam ST_IDLE    = 2'b00;
  localparam ST_PULL    = 2'b01;
  localparam ST_STRETCH = 2'b10;

  reg [1:0]       state_ff;
  reg [STR_W-1:0] cnt_ff;

  // Wait for the pin to really fall before timing the stretch
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= {STR_W{1'b0}};
      o_drive   <= 1'b0;
      o_release <= 1'b0;
    end else begin
      o_release <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (i_trig || i_hold) begin
            state_ff <= ST_PULL;
            o_drive  <= 1'b1;
          end
        end
        ST_PULL: begin
          cnt_ff <= {STR_W{1'b0}};
          if (!i_pin_in && !i_hold) begin
            state_ff <= ST_STRETCH;
          end
        end
        ST_STRETCH: begin
          if (i_hold) begin
            state_ff <= ST_PULL; // Clock fault still present
          end else if (cnt_ff == `STCM_STRETCH_CYC - 5'h01) begin
            state_ff  <= ST_IDLE;
            o_drive   <= 1'b0;
            o_release <= 1'b1; // RL18
          end else begin
            cnt_ff <= cnt_ff + {{(STR_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          o_drive  <= 1'b0;
        end
      endcase
    end
  end

endmodule // stcm_fault_stretch

`default_nettype wire

// *** src/stcm_top.v ***
// Service timer with clock monitor, idle interval counter and APB registers
//
// What this block does
// RL1 - Both detectors stay inactive while reset is held.
// RL2 - After reset both are enabled and the longest window is selected.
// RL3 - Only the first service write sets window and clock monitor enable.
// RL4 - First service write errors unless the key field holds the fixed key.
// RL5 - Later service writes error if window, key or monitor bits differ.
// RL6 - Reads of the service register give zeros in the key field.
// RL7 - The service timer raises no errors in halt or idle mode.
// RL8 - Enabled clock monitor stays active; a stopped halt clock is an error.
// RL9 - R/C option with delay bit clear resumes the window count after halt.
// RL10 - Otherwise halt exit restarts the window; software waits 256 cycles.
// RL11 - Reset never clears or loads the idle interval counter.
// RL12 - Pending flag sets each 4096 cycles; software clears it.
// RL13 - Idle exit is an automatic valid service restarting the window.
// RL14 - First service after reset is never too early.
// RL15 - A service under 256 cycles after window start is an error.
// RL16 - Bits 7:6 select an 8k, 16k, 32k or 64k cycle upper limit.
// RL17 - Bits 5:1 are the key 01100, bit 0 enables the clock monitor.
// RL18 - Fault pin held low 16 cycles past its fall, then released.
// RL19 - Reads return latched window select and monitor enable bits.
//
// Notes for users
// Window limits count core clocks; halt and idle freeze the count.
// The upper limit counts from the last restart of the window.
// A service write while the fault pin is pulled low is ignored.
// A rejected first service latches nothing; the next write is still first.
// The clock monitor treats halt as a stopped clock.
// The idle interval counter starts at zero at power-up and is never reset.
// Unmapped offsets answer with an error response and zero data.
// Only the low byte of a service write is looked at.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`include "stcm_defines.vh"
`default_nettype none

module stcm_top #(
  parameter IDLE_W = 16
) (
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_srst,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg         o_pready,
  output reg  [31:0] o_prdata,
  output reg         o_pslverr,
  // Core power modes and options
  input  wire        i_halt,
  input  wire        i_idle,
  input  wire        i_osc_rc,
  input  wire        i_clk_fail,
  // Fault output pin, open drain
  input  wire        i_fault_output_pin,
  output reg         o_fault_output_pin,
  output reg         o_fault_output_pin_oe,
  // Interrupt
  output reg         o_irq
);

  // ****************************************
  // Register state
  // ****************************************
  reg [1:0]              sel_ff;
  reg                    cm_en_ff;
  reg                    first_done_ff;
  reg                    clock_start_delay_bit_ff;
  reg [`STCM_ST_WIDTH-1:0] status_ff;
  reg [`STCM_ST_WIDTH-1:0] mask_ff;
  reg                    halt_d_ff;
  reg                    idle_d_ff;
  reg [IDLE_W-1:0]       idle_interval_counter = {IDLE_W{1'b0}};

  // ****************************************
  // Helper functions
  // ****************************************
  // Address match against one register offset
  function stcm_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      stcm_hit = (addr == ofs);
    end
  endfunction

  // Sticky update, a set in the same cycle as a clear wins
  function [`STCM_ST_WIDTH-1:0] stcm_sticky;
    input [`STCM_ST_WIDTH-1:0] cur;
    input [`STCM_ST_WIDTH-1:0] clr;
    input [`STCM_ST_WIDTH-1:0] evt;
    begin
      stcm_sticky = (cur & ~clr) | evt;
    end
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  wire setup   = i_psel && !i_penable;
  wire access  = i_psel && i_penable && o_pready;
  wire wr_acc  = access && i_pwrite;
  // Full byte address compare, so aliases answer as unmapped
  wire hit_svc = stcm_hit(i_paddr, `STCM_OFS_SERVICE);
  wire hit_st  = stcm_hit(i_paddr, `STCM_OFS_STATUS);
  wire hit_msk = stcm_hit(i_paddr, `STCM_OFS_MASK);
  wire hit_ctl = stcm_hit(i_paddr, `STCM_OFS_CONTROL);
  wire hit_cnt = stcm_hit(i_paddr, `STCM_OFS_IDLE_CNT);
  wire mapped  = hit_svc || hit_st || hit_msk || hit_ctl || hit_cnt;

  // ****************************************
  // Service write checks
  // ****************************************
  wire [7:0] wbyte    = i_pwdata[7:0];
  wire       key_ok   = (wbyte[`STCM_KEY_HI:`STCM_KEY_LO] == `STCM_KEY_VALUE); // RL17
  wire       fields_ok = key_ok && (wbyte[`STCM_SEL_HI:`STCM_SEL_LO] == sel_ff)
                         && (wbyte[`STCM_CM_BIT] == cm_en_ff); // RL5
  wire       fault_act = o_fault_output_pin_oe;
  // Services are ignored while the fault pin is pulled low
  wire       svc_wr   = wr_acc && hit_svc && !fault_act;
  wire       low_pwr  = i_halt || i_idle;

  // Window timer interface
  wire       win_early;
  wire       win_expired;
  wire       fault_release;

  // Mode exits
  // Exit pulses last one cycle, the cycle after the level drops
  wire halt_exit = halt_d_ff && !i_halt;
  wire idle_exit = idle_d_ff && !i_idle;
  // Restart on halt exit unless the R/C oscillator resumes without delay
  wire halt_restart = halt_exit && (!i_osc_rc || clock_start_delay_bit_ff); // RL10

  // ****************************************
  // Service classification
  // ****************************************
  reg svc_ok;
  reg svc_err;
  // At most one of ok or error per service write
  always @* begin
    svc_ok  = 1'b0;
    svc_err = 1'b0;
    if (svc_wr) begin
      if (!first_done_ff) begin
        svc_ok  = key_ok;           // RL14
        svc_err = !key_ok;          // RL4
      end else if (!fields_ok) begin
        svc_err = 1'b1;             // RL5
      end else if (win_early) begin
        svc_err = 1'b1;             // RL15
      end else begin
        svc_ok  = 1'b1;
      end
    end
  end

  // Service timer detector gated by mode and fault release
  // The expiry flag lingers for the release cycle; masking it there stops a
  // second fault before the restarted window has cleared it
  wire svc_fault   = !low_pwr && !fault_release && (svc_err || win_expired); // RL7
  // Clock monitor ignores halt and idle gating on purpose
  wire clk_fault   = cm_en_ff && (i_clk_fail || i_halt); // RL8
  wire win_restart = svc_ok || idle_exit || halt_restart || fault_release; // RL13

  // ****************************************
  // Window timer
  // ****************************************
  // Counter runs only while the core is awake
  stcm_window_timer #(
    .CNT_W     (17)
  ) u_window (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_restart  (win_restart),
    .i_run      (!low_pwr),         // RL9
    .i_sel      (sel_ff),
    .o_early    (win_early),
    .o_expired  (win_expired)
  );

  // ****************************************
  // Fault pin stretch
  // ****************************************
  // Clock faults hold the pin low, service faults only trigger it
  wire fault_drive;
  stcm_fault_stretch #(
    .STR_W     (5)
  ) u_fault (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),            // RL1
    .i_trig     (svc_fault),
    .i_hold     (clk_fault),
    .i_pin_in   (i_fault_output_pin),
    .o_drive    (fault_drive),
    .o_release  (fault_release)
  );

  // Pin drive registered: output low while enabled
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_fault_output_pin    <= 1'b0;
      o_fault_output_pin_oe <= 1'b0;  // RL1
    end else begin
      o_fault_output_pin    <= 1'b0;
      o_fault_output_pin_oe <= fault_drive; // RL18
    end
  end

  // ****************************************
  // Service settings latch
  // ****************************************
  // First good key latches settings, later writes only compare them
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      sel_ff        <= `STCM_SEL_RESET;  // RL2
      cm_en_ff      <= `STCM_CM_RESET;   // RL2
      first_done_ff <= 1'b0;
    end else if (svc_wr && !first_done_ff && key_ok) begin
      sel_ff        <= wbyte[`STCM_SEL_HI:`STCM_SEL_LO]; // RL3
      cm_en_ff      <= wbyte[`STCM_CM_BIT];              // RL3
      first_done_ff <= 1'b1;
    end
  end

  // ****************************************
  // Mode edge tracking and control bits
  // ****************************************
  // Previous mode levels; reset value is the awake level, so no false exit
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      halt_d_ff <= 1'b0;
      idle_d_ff <= 1'b0;
    end else begin
      halt_d_ff <= i_halt;
      idle_d_ff <= i_idle;
    end
  end

  // Control register, delay bit only matters with the R/C option
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      clock_start_delay_bit_ff <= 1'b0;
    end else if (wr_acc && hit_ctl) begin
      clock_start_delay_bit_ff <= i_pwdata[0];
    end
  end

  // ****************************************
  // Idle interval counter
  // ****************************************
  // Free-running increment
  reg [IDLE_W-1:0] nxt_idle_count;
  always @* begin
    nxt_idle_count = idle_interval_counter + {{(IDLE_W-1){1'b0}}, 1'b1};
  end

  // No reset on purpose, the interval keeps running across resets
  always @(posedge i_core_clk) begin
    idle_interval_counter <= nxt_idle_count; // RL11
  end

  // Next increment toggles the tap bit
  wire idle_tick = &idle_interval_counter[`STCM_IDLE_TAP-1:0]; // RL12

  // ****************************************
  // Sticky status, set wins over clear
  // ****************************************
  wire [`STCM_ST_WIDTH-1:0] st_set = {idle_tick, clk_fault, svc_fault};
  wire [`STCM_ST_WIDTH-1:0] st_clr = (wr_acc && hit_st) ? i_pwdata[`STCM_ST_WIDTH-1:0]
                                                          : {`STCM_ST_WIDTH{1'b0}};
  wire [`STCM_ST_WIDTH-1:0] nxt_status = stcm_sticky(status_ff, st_clr, st_set);

  // Status register
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      status_ff <= {`STCM_ST_WIDTH{1'b0}};
    end else begin
      status_ff <= nxt_status; // RL12
    end
  end

  // Mask register, same layout as status
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      mask_ff <= {`STCM_ST_WIDTH{1'b0}};
    end else if (wr_acc && hit_msk) begin
      mask_ff <= i_pwdata[`STCM_ST_WIDTH-1:0];
    end
  end

  // Level interrupt from the next status, so it rises with the flag
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(nxt_status & mask_ff);
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  // Key positions forced to zero so the key never leaks
  reg [31:0] rdata;
  always @* begin
    rdata = 32'h00000000;
    if (hit_svc) begin
      rdata[`STCM_SEL_HI:`STCM_SEL_LO] = sel_ff;   // RL19
      rdata[`STCM_KEY_HI:`STCM_KEY_LO] = 5'h00;    // RL6
      rdata[`STCM_CM_BIT]              = cm_en_ff; // RL19
    end else if (hit_st) begin
      rdata[`STCM_ST_WIDTH-1:0] = status_ff;
    end else if (hit_msk) begin
      rdata[`STCM_ST_WIDTH-1:0] = mask_ff;
    end else if (hit_ctl) begin
      rdata[0] = clock_start_delay_bit_ff;
    end else if (hit_cnt) begin
      rdata[IDLE_W-1:0] = idle_interval_counter;
    end
  end

  // ****************************************
  // APB response, one wait-free access phase
  // ****************************************
  // Read data captured at setup and standing through the access phase
  // Writes land at the access edge, so back to back transfers are safe
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_pready  <= 1'b1;
      o_prdata  <= i_pwrite ? 32'h00000000 : rdata;
      o_pslverr <= !mapped;
    end else begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

endmodule // stcm_top

`default_nettype wire

// *** verification/stcm_props.sv ***
// Assertion checker on the service timer top ports
`default_nettype none

module stcm_props (
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_srst,
  // APB
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  // Modes and fault pin
  input wire logic        i_halt,
  input wire logic        i_idle,
  input wire logic        i_clk_fail,
  input wire logic        o_fault_output_pin_oe
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  // Zero wait states on every access
  property p_ready_after_setup;
    i_psel && !i_penable |=> o_pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready missing after setup");

  property p_ready_in_access;
    o_pready |-> i_psel && i_penable;
  endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");

  // Holes in the map answer with an error and no data
  property p_unmapped_err;
    o_pready && (i_paddr > 8'h10 || i_paddr[1:0] != 2'h0) |-> o_pslverr && o_prdata == 32'h0;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

  property p_key_hidden;
    o_pready && !i_pwrite && i_paddr == 8'h00 |-> o_prdata[5:1] == 5'h00;
  endproperty
  a_key_hidden: assert property (p_key_hidden) else $error("key field visible");

  // Reset is the only property that must not be masked by reset
  property p_reset_quiet;
    disable iff (1'b0) i_srst |=> !o_fault_output_pin_oe && !o_pready;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("activity during reset");

  property p_stretch_min;
    $rose(o_fault_output_pin_oe) |=> o_fault_output_pin_oe [*8];
  endproperty
  a_stretch_min: assert property (p_stretch_min) else $error("fault pulse too short");

  // Pin is low as soon as driven, so release needs 16 driven cycles
  property p_stretch_end;
    $fell(o_fault_output_pin_oe) && !$past(i_srst) |-> $past(o_fault_output_pin_oe, 16);
  endproperty
  a_stretch_end: assert property (p_stretch_end) else $error("fault released early");

  property p_idle_quiet;
    (i_idle && !i_halt && !i_clk_fail && !o_fault_output_pin_oe) [*3] |=> !o_fault_output_pin_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("fault raised in idle");
endmodule // stcm_props

bind stcm_top stcm_props chk_u (
  .i_core_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_pready, .o_prdata,
  .o_pslverr, .i_halt, .i_idle, .i_clk_fail, .o_fault_output_pin_oe
);

`default_nettype wire

// *** verification/stcm_tb_top.sv ***
// Self-checking bench for the service timer top module
`default_nettype none

module stcm_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Signals and design
  // ****
  logic        clk, srst, psel, pen, pwr, halt, idle, rc, cfail, pready, perr, pdrv, oe, irq, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [15:0] c1;
  wire         pin;
  int          failures, checks, cyc;
  int          seed = 6587;

  stcm_top dut_u (
    .i_core_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(perr),
    .i_halt(halt), .i_idle(idle), .i_osc_rc(rc), .i_clk_fail(cfail), .i_fault_output_pin(pin),
    .o_fault_output_pin(pdrv), .o_fault_output_pin_oe(oe), .o_irq(irq)
  );
  // Open-drain pin with pull-up
  assign pin = oe ? pdrv : 1'b1;

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      complete_run();
    end
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One transfer; request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    chk("pready_wait", 32'(n), 1);
  endtask
  task automatic rdm(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask
  // Random upper bits must be ignored
  task automatic svc(input logic [7:0] b);
    v = $random(seed);
    v[7:0] = b;
    apb(1'b1, 8'h00, v);
  endtask
  task automatic woe(input logic l, input int n);
    while (oe !== l && n > 0) begin
      @(posedge clk);
      n--;
    end
    chk("fault_oe", 32'(oe), 32'(l));
  endtask
  task automatic quiet(input int n);
    repeat (n) @(posedge clk);
    chk("fault_oe", 32'(oe), 0);
  endtask
  // Service error seen, stretched, released and cleared
  task automatic trip();
    woe(1'b1, 16);
    chk("irq", 32'(irq), 1);
    rdm("status", 8'h04, 32'h3, 32'h1);
    woe(1'b0, 40);
    apb(1'b1, 8'h04, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq", 32'(irq), 0);
  endtask
  task automatic do_reset();
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    {srst, psel, pen, pwr, halt, idle, rc, cfail} = 8'h80;
    paddr = 8'h00;
    pwdata = 32'h0;
    cyc = 0;
    do_reset();
    rdm("service", 8'h00, 32'hFF, 32'hC1);
    apb(1'b1, 8'h08, 32'h3);
    tdone("defaults");
    v = $random(seed);
    if (v[5:1] == 5'h0C)
      v[1] = ~v[1];
    svc(v[7:0]);
    trip();
    tdone("bad_first_key");
    svc(8'h18);
    quiet(6);
    rdm("service", 8'h00, 32'hFF, 32'h00);
    tdone("first_service");
    for (int i = 0; i < 3; i++) begin
      repeat (300) @(posedge clk);
      svc(i == 0 ? 8'h58 : (i == 1 ? 8'h19 : 8'h1C));
      trip();
    end
    rdm("service", 8'h00, 32'hFF, 32'h00);
    tdone("mismatch");
    repeat (300) @(posedge clk);
    svc(8'h18);
    quiet(6);
    repeat (100) @(posedge clk);
    svc(8'h18);
    trip();
    tdone("too_early");
    cfail <= 1'b1;
    quiet(20);
    cfail <= 1'b0;
    repeat (300) @(posedge clk);
    idle <= 1'b1;
    svc(8'h58);
    quiet(10);
    idle <= 1'b0;
    svc(8'h18);
    trip();
    tdone("idle");
    repeat (300) @(posedge clk);
    halt <= 1'b1;
    repeat (20) @(posedge clk);
    halt <= 1'b0;
    svc(8'h18);
    trip();
    rc <= 1'b1;
    apb(1'b1, 8'h0C, 32'h0);
    repeat (300) @(posedge clk);
    halt <= 1'b1;
    repeat (20) @(posedge clk);
    halt <= 1'b0;
    svc(8'h18);
    quiet(8180);
    trip();
    tdone("halt_and_window");
    repeat (4100) @(posedge clk);
    rdm("idle_pending", 8'h04, 32'h4, 32'h4);
    // Keep the clear and the re-read away from the next tick
    apb(1'b0, 8'h10, 32'h0);
    if (rd[11:0] > 12'hF00)
      repeat (300) @(posedge clk);
    apb(1'b1, 8'h04, 32'h4);
    rdm("idle_pending", 8'h04, 32'h4, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    c1 = rd[15:0];
    do_reset();
    apb(1'b0, 8'h10, 32'h0);
    chk("idle_count_kept", 32'(rd[15:0] - c1 < 16'h20), 1);
    tdone("idle_counter");
    rdm("service", 8'h00, 32'hFF, 32'hC1);
    halt <= 1'b1;
    woe(1'b1, 8);
    rdm("status", 8'h04, 32'h2, 32'h2);
    halt <= 1'b0;
    woe(1'b0, 40);
    apb(1'b0, 8'h14, 32'h0);
    chk("pslverr", 32'(er), 1);
    chk("unmapped_data", rd, 32'h0);
    tdone("clock_monitor");
    apb(1'b1, 8'h04, 32'h7);
    apb(1'b1, 8'h08, 32'h3);
    svc(8'h58);
    quiet(16372);
    trip();
    rdm("service", 8'h00, 32'hFF, 32'h40);
    tdone("window_16k");
    complete_run();
  end
endmodule // stcm_tb_top

`default_nettype wire
